// >>> hw/lec_core.sv
// Purpose: Length measurer and event counter driven by input terminals
// Assumes: Register port on core_clk; pins asynchronous
// Notes:   Event count is mirrored out for retention storage
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module lec_core
    import lec_pkg::*;
#(
    parameter int NUM_DI = 8,
    parameter int NUM_DO = 5
) (
    input wire logic core_clk, // Core clock, 250 MHz
    input wire logic rst, // Async reset, active high
    input wire logic [ADDR_W-1:0] regAddr, // Register byte address
    input wire logic [DATA_W-1:0] regWrData, // Register write data
    input wire logic regWrStb, // Write strobe
    input wire logic regRdStb, // Read strobe
    output logic [DATA_W-1:0] regRdData, // Read data, cycle after strobe
    input wire logic [NUM_DI-1:0] digitalInputTerminal, // Raw input pins
    output logic [NUM_DO-1:0] relayOutputTerminal, // Output terminals
    input wire logic [15:0] nvRestoreData, // Count read back from storage
    input wire logic nvRestoreStb, // Load count from storage
    output logic [15:0] nvSaveData, // Count to store
    output logic nvSaveStb // Count changed, store it
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // Terminal indices are three bits wide, so eight of each at most
    if (NUM_DI < 1 || NUM_DI > 8) begin : g_di_chk
        $error("NUM_DI must be 1 to 8");
    end
    if (NUM_DO < 1 || NUM_DO > 8) begin : g_do_chk
        $error("NUM_DO must be 1 to 8");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    lec_cfg_t cfg_r;
    lec_reach_t reach_r;
    logic [FUNC_W-1:0] diFunc_r [NUM_DI];
    logic [FUNC_W-1:0] doFunc_r [NUM_DO];
    logic [15:0] measLen_r;
    logic [15:0] measLen_nxt;
    logic [23:0] lenRem_r;
    logic [23:0] lenRem_nxt;
    logic [15:0] eventCnt_r;
    logic [15:0] eventCnt_nxt;
    logic [DATA_W-1:0] rdData_nxt;
    logic [NUM_DO-1:0] doOut_nxt;

    // ----------------------------------------------------------------
    // Input terminal synchronisation
    // ----------------------------------------------------------------
    logic [NUM_DI-1:0] diLevel;
    logic [NUM_DI-1:0] diRise;

    // Pins pass two flops, then one edge per rising transition
    // Clear functions use the level, counting uses the edge
    lec_edge_sync #(
        .WIDTH(NUM_DI)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn(digitalInputTerminal),
        .syncLevel(diLevel),
        .riseStb(diRise)
    );

    // ----------------------------------------------------------------
    // Terminal function routing
    // ----------------------------------------------------------------
    logic [NUM_DI-1:0] isLenIn;
    logic [NUM_DI-1:0] isLenRst;
    logic [NUM_DI-1:0] isCntIn;
    logic [NUM_DI-1:0] isCntRst;

    // Decode each terminal's selected function
    for (genvar i = 0; i < NUM_DI; i++) begin : g_di_dec
        assign isLenIn[i] = (diFunc_r[i] == DI_FN_LEN_IN);
        assign isLenRst[i] = (diFunc_r[i] == DI_FN_LEN_RST);
        assign isCntIn[i] = (diFunc_r[i] == DI_FN_COUNT_IN);
        assign isCntRst[i] = (diFunc_r[i] == DI_FN_COUNT_RST);
    end

    // Any terminal carrying a function may fire it
    wire lenPulse = |(diRise & isLenIn);
    wire lenClear = |(diLevel & isLenRst);
    wire cntPulse = |(diRise & isCntIn);
    wire cntClear = |(diLevel & isCntRst);

    // ----------------------------------------------------------------
    // Register write decode
    // ----------------------------------------------------------------
    // Writes to read-only or unmapped offsets fall through unused
    wire wrTarget = regWrStb && (regAddr == OFF_TARGET_LEN);
    wire wrFactor = regWrStb && (regAddr == OFF_PPM_FACTOR);
    wire wrFinal = regWrStb && (regAddr == OFF_FINAL_CNT);
    wire wrInter = regWrStb && (regAddr == OFF_INTER_CNT);
    wire [15:0] wrVal = regWrData[15:0];
    // Zero is below the legal range for factor and thresholds
    wire [15:0] wrValMin1 = (wrVal == 16'h0000) ? MIN_NONZERO : wrVal;
    // Function registers sit on word steps above their base offsets
    wire [ADDR_W-1:0] diOffs = regAddr - OFF_DI_FUNC;
    wire [ADDR_W-1:0] doOffs = regAddr - OFF_DO_FUNC;
    wire diHit = (regAddr >= OFF_DI_FUNC) && (diOffs[1:0] == 2'b00)
        && (diOffs[ADDR_W-1:2] < 6'(NUM_DI));
    wire doHit = (regAddr >= OFF_DO_FUNC) && (doOffs[1:0] == 2'b00)
        && (doOffs[ADDR_W-1:2] < 6'(NUM_DO));
    wire [2:0] diIdx = diOffs[4:2];
    wire [2:0] doIdx = doOffs[4:2];

    // ----------------------------------------------------------------
    // Settings registers
    // ----------------------------------------------------------------
    // Factor and thresholds store a written zero as one; the target may be zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_r.targetLen <= RST_TARGET_LEN;
            cfg_r.ppmFactor <= RST_PPM_FACTOR;
            cfg_r.finalCnt <= RST_FINAL_CNT;
            cfg_r.interCnt <= RST_INTER_CNT;
        end else begin
            if (wrTarget) begin
                cfg_r.targetLen <= wrVal;
            end
            if (wrFactor) begin
                cfg_r.ppmFactor <= wrValMin1;
            end
            if (wrFinal) begin
                cfg_r.finalCnt <= wrValMin1;
            end
            if (wrInter) begin
                cfg_r.interCnt <= wrValMin1;
            end
        end
    end

    // Input terminal function selections
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_DI; i++) begin
                diFunc_r[i] <= '0;
            end
        end else if (regWrStb && diHit) begin
            diFunc_r[diIdx] <= regWrData[FUNC_W-1:0];
        end
    end

    // Output terminal function selections
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_DO; i++) begin
                doFunc_r[i] <= '0;
            end
        end else if (regWrStb && doHit) begin
            doFunc_r[doIdx] <= regWrData[FUNC_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Length measurement
    // ----------------------------------------------------------------
    // The remainder is kept in tenths of a pulse: each pulse adds ten,
    // and a metre is booked each time the factor fits, so no divider
    // is needed. One metre is booked per cycle at most.
    // The factor never drops below one tenth, and the remainder is
    // dropped once the length saturates, so it cannot run away.
    wire lenFull = (measLen_r == MAX_16);
    wire [23:0] lenAdd = (lenPulse && !lenFull) ? TENTHS_PER_PULSE : 24'h000000;
    wire [23:0] lenSum = lenRem_r + lenAdd;
    wire [23:0] factorW = {8'h00, cfg_r.ppmFactor};
    wire lenStep = (lenSum >= factorW) && !lenFull;

    always_comb begin
        if (lenClear) begin
            measLen_nxt = 16'h0000;
            lenRem_nxt = 24'h000000;
        end else if (lenStep) begin
            measLen_nxt = measLen_r + 16'h0001;
            lenRem_nxt = lenSum - factorW;
        end else begin
            measLen_nxt = measLen_r;
            lenRem_nxt = lenFull ? 24'h000000 : lenSum;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            measLen_r <= 16'h0000;
            lenRem_r <= 24'h000000;
        end else begin
            measLen_r <= measLen_nxt;
            lenRem_r <= lenRem_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Event counter
    // ----------------------------------------------------------------
    // Counting does not look at whether the drive runs; it only stops
    // once the final threshold is reached.
    // Count reset beats a restore and a restore beats a pulse, so a
    // pulse that lands together with a restore is lost on purpose.
    wire cntDone = (eventCnt_r >= cfg_r.finalCnt);

    always_comb begin
        if (cntClear) begin
            eventCnt_nxt = 16'h0000;
        end else if (nvRestoreStb) begin
            eventCnt_nxt = nvRestoreData;
        end else if (cntPulse && !cntDone) begin
            eventCnt_nxt = eventCnt_r + 16'h0001;
        end else begin
            eventCnt_nxt = eventCnt_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eventCnt_r <= 16'h0000;
        end else begin
            eventCnt_r <= eventCnt_nxt;
        end
    end

    // The mirror carries the next count so storage sees it at once;
    // a restore is not echoed back as a save.
    // Mirror count changes out to retention storage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nvSaveData <= 16'h0000;
            nvSaveStb <= 1'b0;
        end else begin
            nvSaveData <= eventCnt_nxt;
            nvSaveStb <= (eventCnt_nxt != eventCnt_r) && !nvRestoreStb;
        end
    end

    // ----------------------------------------------------------------
    // Reached flags
    // ----------------------------------------------------------------
    lec_reach_t reach_nxt;

    // Flags follow the next values so outputs line up with the count
    // Length must exceed target; counts must reach thresholds
    assign reach_nxt.lenReach = (measLen_nxt > cfg_r.targetLen);
    assign reach_nxt.finalReach = !cntClear
        && (eventCnt_nxt >= cfg_r.finalCnt);
    assign reach_nxt.interReach = !cntClear
        && (eventCnt_nxt >= cfg_r.interCnt);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reach_r <= '0;
        end else begin
            reach_r <= reach_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Output terminals
    // ----------------------------------------------------------------
    // Each terminal shows the flag its function code selects. A
    // terminal given both count codes is a software fault and only
    // ever sees one of them here.
    for (genvar j = 0; j < NUM_DO; j++) begin : g_do_sel
        assign doOut_nxt[j] =
            ((doFunc_r[j] == DO_FN_LEN_REACH) && reach_nxt.lenReach)
            || ((doFunc_r[j] == DO_FN_FINAL_REACH) && reach_nxt.finalReach)
            || ((doFunc_r[j] == DO_FN_INTER_REACH) && reach_nxt.interReach);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            relayOutputTerminal <= '0;
        end else begin
            relayOutputTerminal <= doOut_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Register read path
    // ----------------------------------------------------------------
    logic [FUNC_W-1:0] diFuncRd;
    logic [FUNC_W-1:0] doFuncRd;

    // Function reads are gated by the hit flags so the index never
    // reaches past the end of a small array
    assign diFuncRd = diHit ? diFunc_r[diIdx] : '0;
    assign doFuncRd = doHit ? doFunc_r[doIdx] : '0;

    // Select read word; unmapped addresses read zero
    always_comb begin
        rdData_nxt = '0;
        case (regAddr)
            OFF_TARGET_LEN: rdData_nxt = {16'h0000, cfg_r.targetLen};
            OFF_MEAS_LEN: rdData_nxt = {16'h0000, measLen_r};
            OFF_PPM_FACTOR: rdData_nxt = {16'h0000, cfg_r.ppmFactor};
            OFF_FINAL_CNT: rdData_nxt = {16'h0000, cfg_r.finalCnt};
            OFF_INTER_CNT: rdData_nxt = {16'h0000, cfg_r.interCnt};
            OFF_EVENT_CNT: rdData_nxt = {16'h0000, eventCnt_r};
            OFF_STATUS: rdData_nxt = {29'h00000000, reach_r};
            default: begin
                if (diHit) begin
                    rdData_nxt = {27'h0000000, diFuncRd};
                end else if (doHit) begin
                    rdData_nxt = {27'h0000000, doFuncRd};
                end
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            regRdData <= '0;
        end else begin
            regRdData <= regRdStb ? rdData_nxt : '0;
        end
    end

endmodule
`default_nettype wire

// >>> hw/lec_edge_sync.sv
// Purpose: Two-stage synchroniser with rising-edge pulse per bit
// Assumes: Inputs are asynchronous to core_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module lec_edge_sync #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset, active high
    input wire logic [WIDTH-1:0] asyncIn, // Raw pin levels
    output logic [WIDTH-1:0] syncLevel, // Synchronised levels
    output logic [WIDTH-1:0] riseStb // One-cycle rising-edge pulses
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stable_r;
    logic [WIDTH-1:0] prev_r;

    // ----------------------------------------------------------------
    // Synchroniser and edge history
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            stable_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= asyncIn;
            stable_r <= meta_r;
            prev_r <= stable_r;
        end
    end

    // Edge taken from stable stages only
    assign syncLevel = stable_r;
    assign riseStb = stable_r & ~prev_r;

endmodule
`default_nettype wire

// >>> hw/lec_pkg.sv
// Purpose: Shared constants and types for the length and event counter
// Assumes: 32-bit register port, word-aligned byte addresses
// Notes:   Function codes select what each terminal does
package lec_pkg;

    // ----------------------------------------------------------------
    // Register port geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_TARGET_LEN = 8'h00;
    localparam logic [7:0] OFF_MEAS_LEN = 8'h04;
    localparam logic [7:0] OFF_PPM_FACTOR = 8'h08;
    localparam logic [7:0] OFF_FINAL_CNT = 8'h0C;
    localparam logic [7:0] OFF_INTER_CNT = 8'h10;
    localparam logic [7:0] OFF_EVENT_CNT = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_DI_FUNC = 8'h20;
    localparam logic [7:0] OFF_DO_FUNC = 8'h40;

    // ----------------------------------------------------------------
    // Status register bit positions
    // ----------------------------------------------------------------
    localparam int ST_LEN_REACH = 0;
    localparam int ST_FINAL_REACH = 1;
    localparam int ST_INTER_REACH = 2;

    // ----------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_TARGET_LEN = 16'h03E8;
    localparam logic [15:0] RST_PPM_FACTOR = 16'h03E8;
    localparam logic [15:0] RST_FINAL_CNT = 16'h03E8;
    localparam logic [15:0] RST_INTER_CNT = 16'h03E8;
    localparam logic [15:0] MAX_16 = 16'hFFFF;
    localparam logic [15:0] MIN_NONZERO = 16'h0001;
    localparam logic [23:0] TENTHS_PER_PULSE = 24'h00000A;

    // ----------------------------------------------------------------
    // Terminal function codes
    // ----------------------------------------------------------------
    localparam int FUNC_W = 5;
    localparam logic [4:0] DI_FN_COUNT_IN = 5'h1B;
    localparam logic [4:0] DI_FN_COUNT_RST = 5'h1C;
    localparam logic [4:0] DI_FN_LEN_IN = 5'h1D;
    localparam logic [4:0] DI_FN_LEN_RST = 5'h1E;
    localparam logic [4:0] DO_FN_FINAL_REACH = 5'h1D;
    localparam logic [4:0] DO_FN_INTER_REACH = 5'h1E;
    localparam logic [4:0] DO_FN_LEN_REACH = 5'h1F;

    // ----------------------------------------------------------------
    // Software settings carried as one bundle
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] targetLen;
        logic [15:0] ppmFactor;
        logic [15:0] finalCnt;
        logic [15:0] interCnt;
    } lec_cfg_t;

    // Reached flags carried as one bundle
    typedef struct packed {
        logic interReach;
        logic finalReach;
        logic lenReach;
    } lec_reach_t;

endpackage

// >>> tb/lec_core_monitor.sv
// Purpose: Port-level checks for the length and event counter
// Assumes: Bound to every lec_core instance
// Notes:   The event count is watched through its retention mirror
`timescale 1ns/10ps
`default_nettype none
module lec_core_monitor
    import lec_pkg::*;
#(
    parameter int NUM_DI = 8,
    parameter int NUM_DO = 5
) (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset
    input wire logic [ADDR_W-1:0] regAddr, // Register address
    input wire logic regRdStb, // Read strobe
    input wire logic [DATA_W-1:0] regRdData, // Read data
    input wire logic [15:0] nvRestoreData, // Restore value
    input wire logic nvRestoreStb, // Restore strobe
    input wire logic [15:0] nvSaveData, // Count mirror
    input wire logic nvSaveStb // Count change pulse
);
    // ------------------------------------------------------------
    // Register port and count mirror checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_RD_IDLE: assert property (!$past(regRdStb) |-> regRdData == '0)
        else $error("read data outside its slot");
    AST_RD_UNMAPPED: assert property (($past(regRdStb) && ($past(regAddr) == 8'h1C
        || $past(regAddr) >= 8'h60)) |-> regRdData == '0)
        else $error("unmapped read not zero");
    AST_RD_WIDTH: assert property (($past(regRdStb) && $past(regAddr) <= OFF_EVENT_CNT)
        |-> regRdData[31:16] == 16'h0000)
        else $error("upper bits of a value set");
    AST_STATUS_WIDTH: assert property (($past(regRdStb) && $past(regAddr) == OFF_STATUS)
        |-> regRdData[31:3] == 29'h0)
        else $error("status spare bits set");
    AST_CNT_MIRROR: assert property (($past(regRdStb) && $past(regAddr) == OFF_EVENT_CNT)
        |-> regRdData[15:0] == $past(nvSaveData))
        else $error("count read differs from mirror");
    AST_CNT_STEP: assert property (($changed(nvSaveData) && nvSaveData != 16'h0000
        && !$past(nvRestoreStb) && !$past(nvRestoreStb, 2) && !$past(nvRestoreStb, 3))
        |-> nvSaveData == $past(nvSaveData) + 16'h0001)
        else $error("count moved by other than one");
    AST_SAVE_PULSE: assert property (nvSaveStb |-> !$past(nvRestoreStb))
        else $error("save strobe on a restore");
    AST_SAVE_CAUSE: assert property (nvSaveStb |-> $changed(nvSaveData))
        else $error("save strobe without a count change");
    AST_RESTORE: assert property ($past(nvRestoreStb, 2)
        |-> nvSaveData == $past(nvRestoreData, 2))
        else $error("restored count not mirrored");
endmodule
bind lec_core lec_core_monitor #(.NUM_DI(NUM_DI), .NUM_DO(NUM_DO)) mon (.core_clk(core_clk),
    .rst(rst), .regAddr(regAddr), .regRdStb(regRdStb), .regRdData(regRdData),
    .nvRestoreData(nvRestoreData), .nvRestoreStb(nvRestoreStb), .nvSaveData(nvSaveData),
    .nvSaveStb(nvSaveStb));
`default_nettype wire

// >>> tb/lec_core_tb.sv
// Purpose: Self-checking bench for the length and event counter
// Assumes: Default terminal counts, 250 MHz clock
// Notes:   Read results are queued by the driver and checked by a watcher
`timescale 1ns/10ps
`default_nettype none
module lec_core_tb;
    import lec_pkg::*;
    logic core_clk, rst, regWrStb, regRdStb, start, busy, nvRestoreStb, nvSaveStb;
    logic rdPend = 1'b0;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData;
    logic [7:0] pins, nPulses;
    logic [2:0] pinIdx;
    logic [4:0] relay;
    logic [15:0] nvRestoreData, nvSaveData, inter, keep;
    logic [31:0] seed;
    logic [DATA_W-1:0] expQ[$];
    int badCount, nCompared, cycles;
    lec_core uut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .digitalInputTerminal(pins), .relayOutputTerminal(relay),
        .nvRestoreData(nvRestoreData), .nvRestoreStb(nvRestoreStb),
        .nvSaveData(nvSaveData), .nvSaveStb(nvSaveStb));
    lec_pulse_src src (.core_clk(core_clk), .rst(rst), .start(start), .pinIdx(pinIdx),
        .nPulses(nPulses), .pins(pins), .busy(busy));
    // ------------------------------------------------------------
    // Clock, timeout and read watcher
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            stopTest();
        end
    end
    // Oldest noted read result against the data in its slot
    always @(posedge core_clk) begin
        if (rdPend) begin
            check(regRdData, expQ.pop_front());
        end
        rdPend = regRdStb;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regRdStb <= 1'b1;
        regAddr <= a;
        expQ.push_back(exp);
        @(posedge core_clk);
        regRdStb <= 1'b0;
    endtask
    task automatic pulses(input logic [2:0] idx, input logic [7:0] n);
        int k;
        @(posedge core_clk);
        start <= 1'b1;
        pinIdx <= idx;
        nPulses <= n;
        @(posedge core_clk);
        start <= 1'b0;
        @(posedge core_clk);
        k = 0;
        while (busy === 1'b1 && k < 200) begin
            k++;
            @(posedge core_clk);
        end
        repeat (8) @(posedge core_clk);
    endtask
    task automatic stopTest();
        $display("compared %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {regWrStb, regRdStb, start, nvRestoreStb} = 4'h0;
        {regAddr, regWrData, nPulses, pinIdx, nvRestoreData} = '0;
        seed = 32'h7B25628D;
        rst = 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(OFF_TARGET_LEN, 32'h000003E8);
        rd(OFF_MEAS_LEN, 32'h00000000);
        rd(OFF_PPM_FACTOR, 32'h000003E8);
        rd(OFF_FINAL_CNT, 32'h000003E8);
        rd(OFF_INTER_CNT, 32'h000003E8);
        rd(OFF_STATUS, 32'h00000000);
        rd(8'h1C, 32'h00000000);
        wr(OFF_MEAS_LEN, 32'h00000055);
        rd(OFF_MEAS_LEN, 32'h00000000);
        $display("test reset values done");
        wr(OFF_PPM_FACTOR, 32'h00000000);
        rd(OFF_PPM_FACTOR, 32'h00000001);
        wr(OFF_PPM_FACTOR, 32'h0000FFFF);
        rd(OFF_PPM_FACTOR, 32'h0000FFFF);
        wr(OFF_INTER_CNT, 32'h00000000);
        rd(OFF_INTER_CNT, 32'h00000001);
        wr(OFF_FINAL_CNT, 32'h00000000);
        rd(OFF_FINAL_CNT, 32'h00000001);
        wr(OFF_TARGET_LEN, 32'h00000000);
        rd(OFF_TARGET_LEN, 32'h00000000);
        $display("test limits done");
        wr(OFF_DI_FUNC + 8'h04, {27'h0, DI_FN_LEN_IN});
        wr(OFF_DI_FUNC + 8'h0C, {27'h0, DI_FN_LEN_RST});
        wr(OFF_DO_FUNC + 8'h08, {27'h0, DO_FN_LEN_REACH});
        wr(OFF_PPM_FACTOR, 32'h00000014);
        wr(OFF_TARGET_LEN, 32'h00000002);
        pulses(3'h1, 8'h04);
        rd(OFF_MEAS_LEN, 32'h00000002);
        check({27'h0, relay}, 32'h00000000);
        pulses(3'h1, 8'h02);
        rd(OFF_MEAS_LEN, 32'h00000003);
        check({27'h0, relay}, 32'h00000004);
        rd(OFF_STATUS, 32'h00000001);
        pulses(3'h3, 8'h01);
        rd(OFF_MEAS_LEN, 32'h00000000);
        check({27'h0, relay}, 32'h00000000);
        $display("test length done");
        seed = lfsr(seed);
        inter = {14'h0, seed[1:0]} + 16'h0001;
        wr(OFF_DI_FUNC, {27'h0, DI_FN_COUNT_IN});
        wr(OFF_DI_FUNC + 8'h10, {27'h0, DI_FN_COUNT_RST});
        wr(OFF_DO_FUNC, {27'h0, DO_FN_FINAL_REACH});
        wr(OFF_DO_FUNC + 8'h04, {27'h0, DO_FN_INTER_REACH});
        wr(OFF_FINAL_CNT, {16'h0, inter + 16'h0002});
        wr(OFF_INTER_CNT, {16'h0, inter});
        pulses(3'h0, inter[7:0]);
        rd(OFF_EVENT_CNT, {16'h0, inter});
        check({27'h0, relay}, 32'h00000002);
        pulses(3'h0, 8'h04);
        rd(OFF_EVENT_CNT, {16'h0, inter + 16'h0002});
        check({27'h0, relay}, 32'h00000003);
        check({16'h0, nvSaveData}, {16'h0, inter + 16'h0002});
        rd(OFF_STATUS, 32'h00000006);
        pulses(3'h4, 8'h01);
        rd(OFF_EVENT_CNT, 32'h00000000);
        check({27'h0, relay}, 32'h00000000);
        $display("test count done");
        seed = lfsr(seed);
        keep = {8'h00, seed[7:0]};
        @(posedge core_clk);
        nvRestoreData <= keep;
        nvRestoreStb <= 1'b1;
        @(posedge core_clk);
        nvRestoreStb <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(OFF_EVENT_CNT, {16'h0, keep});
        repeat (4) @(posedge core_clk);
        $display("test restore done");
        stopTest();
    end
endmodule
`default_nettype wire

// >>> tb/lec_pulse_src.sv
// Purpose: Pulse source standing on the input terminals
// Assumes: Bursts on one terminal at a time
// Notes:   Each pulse is three cycles high then three low
`timescale 1ns/10ps
`default_nettype none
module lec_pulse_src (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset
    input wire logic start, // Begin a burst
    input wire logic [2:0] pinIdx, // Terminal to pulse
    input wire logic [7:0] nPulses, // Pulses in the burst
    output logic [7:0] pins, // Terminal levels
    output logic busy // Burst in progress
);
    logic [2:0] phase_r;
    logic [7:0] left_r;
    logic [2:0] sel_r;
    // Burst sequencer, spacing wide enough for the input synchroniser
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins <= 8'h00;
            busy <= 1'b0;
            phase_r <= 3'h0;
            left_r <= 8'h00;
            sel_r <= 3'h0;
        end else if (start && !busy) begin
            busy <= 1'b1;
            left_r <= nPulses;
            sel_r <= pinIdx;
            phase_r <= 3'h0;
        end else if (busy) begin
            pins <= (phase_r < 3'h3) ? (8'h01 << sel_r) : 8'h00;
            if (phase_r == 3'h5) begin
                phase_r <= 3'h0;
                left_r <= left_r - 8'h01;
                busy <= (left_r != 8'h01);
            end else begin
                phase_r <= phase_r + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire
